// ### core/msc_control.sv
`timescale 1ns/100ps
// Behaviour
// RULE_01: single-direction force makes all unidirectional vectors share one direction
// RULE_02: sender sets single-direction force only with dual-reference search control
// RULE_03: bidirectional term weights forward/backward by a legal six-bit weight
// RULE_04: extended cost bit selects 12-bit cost ceiling, else 10-bit
// RULE_05: partitions above vector limit rejected; zero allows skip only; 16x16 source
// RULE_06: early exit ends integer search when distortion below decoded threshold
// RULE_07: early exit only on reference zero; distortion chosen by source shape
// RULE_08: transform-size update sets large transform flag from sub-partition size
// RULE_09: horizontal-only bit disables vertical search steps
// RULE_10: early success with master enable skips refinement and intra check
// RULE_11: whole-block bidirectional decision or per-subblock decision
// RULE_12: sender clears whole-block decision when any minor shape present
// RULE_13: sender enables adaptive walk only after two preceding search steps
// RULE_14: skip check runs before integer search when enabled
// RULE_15: seven transform skip thresholds picked by coefficient row plus column
// RULE_16: refinement direction two bits per block, only low bit used
// RULE_17: refinement shape two bits per block decoded to four shapes
// RULE_18: macroblock type input uses output encoding
// RULE_19: vector cost interpolated linearly between eight decoded control points
// RULE_20: chroma penalty scaled zero, once or twice by mode
// RULE_21: reference cost base scaled differently in AVC and linear modes
// RULE_22: shapes mapped to four cost centres, separately per direction
// RULE_23: reserved and invalid fields ignored
module msc_control #(
  parameter int unsigned DIST_W = 16,
  parameter int unsigned TERM_W = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [2:0] search_control_select,
  input wire logic cost_mode_linear,
  input wire logic start,
  input wire logic step_done,
  input wire logic early_full_pel,
  input wire logic [1:0] ref_index,
  input wire logic [DIST_W-1:0] dist_16x16,
  input wire logic [DIST_W-1:0] dist_16x8,
  input wire logic [DIST_W-1:0] dist_8x8,
  input wire logic [5:0] result_vector_count,
  input wire logic inter_all_8x8,
  input wire logic large_transform_flag_in,
  input wire logic [TERM_W-1:0] fwd_term,
  input wire logic [TERM_W-1:0] bwd_term,
  input wire logic [1:0] coeff_row,
  input wire logic [1:0] coeff_col,
  input wire logic [6:0] mv_distance,
  input wire logic [1:0] chroma_mode,
  input wire logic lookup_req,
  input wire logic lookup_bwd,
  input wire logic [1:0] lookup_part,
  output logic phase_skip,
  output logic phase_integer,
  output logic phase_refine,
  output logic phase_intra,
  output logic phase_done,
  output logic search_y_enable,
  output logic single_direction_force,
  output logic whole_block_bidir_decision,
  output logic adaptive_walk_enable,
  output logic [3:0] block_backward,
  output logic [7:0] block_shape_input,
  output logic [1:0] macroblock_type_input,
  output logic early_stop_q,
  output logic partition_ok_q,
  output logic large_transform_flag_q,
  output logic [TERM_W-1:0] bidir_term_q,
  output logic bidir_valid_q,
  output logic [15:0] skip_threshold_q,
  output logic [11:0] mv_cost_q,
  output logic [11:0] chroma_penalty_q,
  output logic [15:0] ref_cost_q,
  output logic [15:0] centre_dx,
  output logic [15:0] centre_dy,
  output logic centre_valid
);
  if (DIST_W < msc_pkg::THR_W || TERM_W < 1) begin : g_bad
    $error("msc_control: DIST_W must hold the exit threshold");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] ctrl1_q;
  logic [31:0] ctrl0_q;
  logic [31:0] cost_q [msc_pkg::COST_WORDS];
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  logic cc_rd_q;
  wire in_cost = addr >= msc_pkg::A_COST0 && addr < msc_pkg::A_CC0;
  wire in_cc = addr >= msc_pkg::A_CC0 && addr < msc_pkg::A_STATUS;
  wire [2:0] cost_idx = 3'((addr - msc_pkg::A_COST0) >> 2);
  wire [2:0] cc_idx = 3'((addr - msc_pkg::A_CC0) >> 2);
  wire aligned = addr[1:0] == 2'h0;
  wire wr_ctrl1 = wr && addr == msc_pkg::A_CTRL1;
  wire wr_ctrl0 = wr && addr == msc_pkg::A_CTRL0;
  wire wr_cost = wr && in_cost && aligned;
  wire wr_cc = wr && in_cc && aligned;
  wire rd_cc = rd && in_cc && aligned;
  // Field 5 of the cost block carries reserved holes
  wire [31:0] cost_mask = cost_idx == 3'h5 ? msc_pkg::COST5_MASK : msc_pkg::FULL_MASK;

  // Reserved bits are dropped at write time, so they read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_q <= msc_pkg::RST_WORD;
      ctrl0_q <= msc_pkg::RST_WORD;
    end else if (ce) begin
      if (wr_ctrl1) begin
        ctrl1_q <= wdata & msc_pkg::CTRL1_MASK; // RULE_23
      end
      if (wr_ctrl0) begin
        ctrl0_q <= wdata & msc_pkg::CTRL0_MASK; // RULE_23
      end
    end
  end

  // Cost words
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < msc_pkg::COST_WORDS; i++) begin
        cost_q[i] <= msc_pkg::RST_WORD;
      end
    end else if (ce && wr_cost) begin
      cost_q[cost_idx] <= wdata & cost_mask; // RULE_23
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire dual_sel = search_control_select == msc_pkg::SC_DUAL;
  wire [5:0] weight = ctrl1_q[msc_pkg::BIWT_LSB +: 6];
  wire ext_range = ctrl1_q[msc_pkg::EXTC_BIT];
  wire [5:0] vec_limit = ctrl1_q[msc_pkg::VLIM_LSB +: 6];
  wire early_en = ctrl0_q[msc_pkg::EARLY_BIT];
  wire skip_en = ctrl0_q[msc_pkg::SKIP_BIT];
  wire t8_en = ctrl0_q[msc_pkg::T8_BIT];
  wire [31:0] refine_word = cost_q[5];
  wire [7:0] dir_field = refine_word[msc_pkg::DIR_LSB +: 8];

  // Force is held low outside dual-reference search
  assign single_direction_force = ctrl1_q[msc_pkg::UNI_BIT] && dual_sel; // RULE_01 RULE_02
  assign search_y_enable = !ctrl0_q[msc_pkg::XONLY_BIT]; // RULE_09
  assign whole_block_bidir_decision = ctrl0_q[msc_pkg::BIMIX_BIT]; // RULE_11 RULE_12
  assign adaptive_walk_enable = ctrl0_q[msc_pkg::ADAPT_BIT]; // RULE_13
  assign block_shape_input = refine_word[msc_pkg::SHAPE_LSB +: 8]; // RULE_17
  assign macroblock_type_input = refine_word[msc_pkg::MBT_LSB +: 2]; // RULE_18

  // Only the low bit of each direction pair steers refinement
  for (genvar b = 0; b < 4; b++) begin : g_dir
    assign block_backward[b] = dir_field[2 * b]; // RULE_16
  end
  wire dir_illegal = dir_field[7:6] == msc_pkg::DIR_ILLEGAL
    || dir_field[5:4] == msc_pkg::DIR_ILLEGAL
    || dir_field[3:2] == msc_pkg::DIR_ILLEGAL
    || dir_field[1:0] == msc_pkg::DIR_ILLEGAL;

  // ----------------------------------------
  // Cost code decoders
  // ----------------------------------------
  logic [msc_pkg::THR_W-1:0] thr_val;
  logic [msc_pkg::PEN_W-1:0] chroma_val;
  logic [msc_pkg::PEN_W-1:0] refc_val;
  logic [msc_pkg::MVC_W-1:0] cp [8];
  wire [63:0] cp_codes = {cost_q[4], cost_q[3]};

  msc_me_decode #(.OUT_W(msc_pkg::THR_W)) u_thr (
    .code(ctrl0_q[msc_pkg::THR_LSB +: 8]),
    .value(thr_val)
  );
  msc_me_decode #(.OUT_W(msc_pkg::PEN_W)) u_chroma (
    .code(cost_q[2][msc_pkg::CHROMA_LSB +: 8]),
    .value(chroma_val)
  );
  msc_me_decode #(.OUT_W(msc_pkg::PEN_W)) u_refc (
    .code(cost_q[2][msc_pkg::REFC_LSB +: 8]),
    .value(refc_val)
  );
  for (genvar k = 0; k < 8; k++) begin : g_cp
    msc_me_decode #(.OUT_W(msc_pkg::MVC_W)) u_cp (
      .code(cp_codes[8 * k +: 8]),
      .value(cp[k])
    );
  end

  // ----------------------------------------
  // Early exit
  // ----------------------------------------
  logic [DIST_W-1:0] exit_dist;
  wire [1:0] src_mode = macroblock_type_input;
  // 8x16 sources fall back on the 16x16 distortion
  assign exit_dist = src_mode == msc_pkg::MB_8X8 ? dist_8x8 :
    src_mode == msc_pkg::MB_16X8 ? dist_16x8 : dist_16x16; // RULE_07
  wire exit_hit = early_en && ref_index == 2'h0
    && exit_dist < DIST_W'(thr_val); // RULE_06 RULE_07

  // ----------------------------------------
  // Search sequencer
  // ----------------------------------------
  msc_pkg::msc_state_type state_q;
  msc_pkg::msc_state_type state_d;
  wire early_now = state_q == msc_pkg::ST_INTEGER && exit_hit;
  // Early success at a full-pel spot bypasses refinement and intra
  wire skip_rest = early_now && early_full_pel && early_en; // RULE_10

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      msc_pkg::ST_IDLE: begin
        if (start) begin
          state_d = skip_en ? msc_pkg::ST_SKIP : msc_pkg::ST_INTEGER; // RULE_14
        end
      end
      msc_pkg::ST_SKIP: begin
        if (step_done) begin
          state_d = msc_pkg::ST_INTEGER; // RULE_14
        end
      end
      msc_pkg::ST_INTEGER: begin
        if (skip_rest) begin
          state_d = msc_pkg::ST_DONE; // RULE_10
        end else if (early_now || step_done) begin
          state_d = msc_pkg::ST_REFINE; // RULE_06
        end
      end
      msc_pkg::ST_REFINE: begin
        if (step_done) begin
          state_d = msc_pkg::ST_INTRA;
        end
      end
      msc_pkg::ST_INTRA: begin
        if (step_done) begin
          state_d = msc_pkg::ST_DONE;
        end
      end
      msc_pkg::ST_DONE: begin
        state_d = msc_pkg::ST_IDLE;
      end
      default: begin
        state_d = msc_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state and exit flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= msc_pkg::ST_IDLE;
      early_stop_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      early_stop_q <= early_now; // RULE_06
    end
  end

  assign phase_skip = state_q == msc_pkg::ST_SKIP;
  assign phase_integer = state_q == msc_pkg::ST_INTEGER;
  assign phase_refine = state_q == msc_pkg::ST_REFINE;
  assign phase_intra = state_q == msc_pkg::ST_INTRA;
  assign phase_done = state_q == msc_pkg::ST_DONE;

  // ----------------------------------------
  // Partition and transform decisions
  // ----------------------------------------
  // Limit matters only for a 16x16 source; zero leaves skip alone
  wire part_ok = src_mode != msc_pkg::MB_16X16
    || (vec_limit != 6'h00 && result_vector_count <= vec_limit); // RULE_05
  wire t8_next = t8_en ? inter_all_8x8 : large_transform_flag_in; // RULE_08

  // ----------------------------------------
  // Bidirectional blend
  // ----------------------------------------
  wire wt_legal = weight == msc_pkg::WT_A || weight == msc_pkg::WT_B
    || weight == msc_pkg::WT_C || weight == msc_pkg::WT_D
    || weight == msc_pkg::WT_E; // RULE_03
  wire [6:0] inv_wt = msc_pkg::WT_FULL - {1'b0, weight};
  wire [TERM_W+7:0] blend = (TERM_W + 8)'(fwd_term * inv_wt)
    + (TERM_W + 8)'(bwd_term * weight); // RULE_03

  // ----------------------------------------
  // Transform skip threshold select
  // ----------------------------------------
  wire [2:0] thr_idx = {1'b0, coeff_row} + {1'b0, coeff_col}; // RULE_15
  wire [47:0] small_thr = {cost_q[7], cost_q[6][31:16]};
  wire [15:0] skip_thr = thr_idx == 3'h0 ? cost_q[6][15:0] :
    {8'h00, small_thr[8 * (thr_idx - 3'h1) +: 8]}; // RULE_15

  // ----------------------------------------
  // Vector cost interpolation
  // ----------------------------------------
  logic [2:0] seg;
  logic [2:0] seg_lw;
  logic [6:0] seg_x;
  logic signed [12:0] seg_diff;
  logic signed [20:0] seg_prod;
  logic [12:0] interp;
  logic [11:0] mv_cost_d;
  wire [11:0] cost_cap = ext_range ? msc_pkg::COST_MAX_EXT : msc_pkg::COST_MAX_LEG; // RULE_04

  // Control points sit at 0,1,2,4,...,64; segment width is a power of two
  always_comb begin
    seg = 3'h0;
    seg_lw = 3'h0;
    seg_x = 7'h00;
    for (int s = 1; s < 7; s++) begin
      if (mv_distance >= 7'(1 << (s - 1))) begin
        seg = 3'(s);
        seg_x = 7'(1 << (s - 1));
        seg_lw = 3'(s - 1);
      end
    end
    seg_diff = 13'(signed'({1'b0, cp[seg + 3'h1]}))
      - 13'(signed'({1'b0, cp[seg]})); // RULE_19
    seg_prod = 21'(seg_diff * signed'({1'b0, mv_distance - seg_x}));
    interp = 13'({3'h0, cp[seg]}) + 13'(seg_prod >>> seg_lw); // RULE_19
    if (mv_distance >= msc_pkg::MV_CLAMP) begin
      interp = {3'h0, cp[7]};
    end
    mv_cost_d = interp > {1'b0, cost_cap} ? cost_cap : interp[11:0]; // RULE_04
  end

  // ----------------------------------------
  // Penalties
  // ----------------------------------------
  wire [11:0] chroma_d = chroma_mode == msc_pkg::CHR_DC ? 12'h000 :
    chroma_mode == msc_pkg::CHR_PLANE ? 12'(chroma_val << 1) : chroma_val; // RULE_20
  // Linear mode grows with the index; AVC mode charges by bit length
  wire [2:0] avc_len = ref_index == 2'h0 ? 3'h1 : (ref_index == 2'h1 ? 3'h1 : 3'h2);
  wire [15:0] ref_cost_d = cost_mode_linear ? 16'(refc_val * ref_index)
    : 16'(refc_val * avc_len); // RULE_21

  // Registered results
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      partition_ok_q <= 1'b0;
      large_transform_flag_q <= 1'b0;
      bidir_term_q <= '0;
      bidir_valid_q <= 1'b0;
      skip_threshold_q <= 16'h0000;
      mv_cost_q <= 12'h000;
      chroma_penalty_q <= 12'h000;
      ref_cost_q <= 16'h0000;
    end else if (ce) begin
      partition_ok_q <= part_ok; // RULE_05
      large_transform_flag_q <= t8_next; // RULE_08
      bidir_term_q <= blend[TERM_W+5:6]; // RULE_03
      bidir_valid_q <= wt_legal && dual_sel; // RULE_03
      skip_threshold_q <= skip_thr;
      mv_cost_q <= mv_cost_d;
      chroma_penalty_q <= chroma_d;
      ref_cost_q <= ref_cost_d;
    end
  end

  // ----------------------------------------
  // Cost centres
  // ----------------------------------------
  logic [31:0] cc_rdata;
  logic lookup_q;
  logic [1:0] centre;
  // First shape of every type shares centre zero
  always_comb begin
    unique case (macroblock_type_input)
      msc_pkg::MB_16X16: centre = 2'h0;
      msc_pkg::MB_16X8: centre = lookup_part[0] ? 2'h2 : 2'h0; // RULE_22
      msc_pkg::MB_8X16: centre = lookup_part[0] ? 2'h1 : 2'h0; // RULE_22
      msc_pkg::MB_8X8: centre = lookup_part; // RULE_22
    endcase
  end
  // Words alternate forward then backward for each centre
  wire [2:0] lookup_addr = {centre, lookup_bwd}; // RULE_22
  // Bus reads win the single read port
  wire mem_re = rd_cc || lookup_req;

  msc_word_mem #(.W(32), .DEPTH(msc_pkg::CC_WORDS)) u_cc (
    .ref_clk(ref_clk),
    .ce(ce),
    .we(wr_cc),
    .waddr(cc_idx),
    .wdata(wdata),
    .re(mem_re),
    .raddr(rd_cc ? cc_idx : lookup_addr),
    .rdata_q(cc_rdata)
  );

  assign centre_dx = cc_rdata[15:0];
  assign centre_dy = cc_rdata[31:16];
  assign centre_valid = lookup_q && !cc_rd_q;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [31:0] status_word = {24'h000000, dir_illegal, wt_legal, early_stop_q,
    phase_done, 1'b0, state_q};
  assign rd_mux = addr == msc_pkg::A_CTRL1 ? ctrl1_q :
    addr == msc_pkg::A_CTRL0 ? ctrl0_q :
    in_cost && aligned ? cost_q[cost_idx] :
    addr == msc_pkg::A_STATUS ? status_word : 32'h0000_0000;

  // Data live only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
      cc_rd_q <= 1'b0;
      lookup_q <= 1'b0;
    end else if (ce) begin
      rdata_q <= rd && !rd_cc ? rd_mux : 32'h0000_0000;
      cc_rd_q <= rd_cc;
      lookup_q <= lookup_req && !rd_cc;
    end
  end

  assign rdata = cc_rd_q ? cc_rdata : rdata_q;
endmodule

// ### core/msc_me_decode.sv
`timescale 1ns/100ps
// ----------------------------------------
// Mantissa-exponent cost code to value
// ----------------------------------------
module msc_me_decode #(
  parameter int unsigned OUT_W = 12
) (
  input wire logic [7:0] code,
  output logic [OUT_W-1:0] value
);
  logic [18:0] wide;
  logic over;

  if (OUT_W < 4 || OUT_W > 19) begin : g_bad
    $error("msc_me_decode: OUT_W out of range");
  end

  // Low nibble mantissa, high nibble shift
  assign wide = {15'h0000, code[3:0]} << code[7:4];
  // Codes beyond the field width saturate rather than wrap
  assign over = (wide >> OUT_W) != 19'h00000;
  assign value = over ? {OUT_W{1'b1}} : wide[OUT_W-1:0];
endmodule

// ### core/msc_word_mem.sv
`timescale 1ns/100ps
// ----------------------------------------
// Small word store, registered read
// ----------------------------------------
module msc_word_mem #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic re,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata_q
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("msc_word_mem: DEPTH must be a power of two");
  end

  // No reset: contents are defined by software before use
  always_ff @(posedge ref_clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule

// ### pkg/msc_pkg.sv
package msc_pkg;
  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] A_CTRL1 = 8'h00;
  localparam logic [7:0] A_CTRL0 = 8'h04;
  localparam logic [7:0] A_COST0 = 8'h08;
  localparam logic [7:0] A_CC0 = 8'h28;
  localparam logic [7:0] A_STATUS = 8'h48;
  localparam int unsigned COST_WORDS = 8;
  localparam int unsigned CC_WORDS = 8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Writable bits; reserved bits store and read zero
  localparam logic [31:0] CTRL1_MASK = 32'h103F_FF7F;
  localparam logic [31:0] CTRL0_MASK = 32'hFF00_00E7;
  localparam logic [31:0] COST5_MASK = 32'h00FF_FF03;
  localparam logic [31:0] FULL_MASK = 32'hFFFF_FFFF;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned UNI_BIT = 28;
  localparam int unsigned BIWT_LSB = 16;
  localparam int unsigned EXTC_BIT = 6;
  localparam int unsigned VLIM_LSB = 0;
  localparam int unsigned THR_LSB = 24;
  localparam int unsigned T8_BIT = 7;
  localparam int unsigned XONLY_BIT = 6;
  localparam int unsigned EARLY_BIT = 5;
  localparam int unsigned BIMIX_BIT = 2;
  localparam int unsigned ADAPT_BIT = 1;
  localparam int unsigned SKIP_BIT = 0;
  localparam int unsigned DIR_LSB = 16;
  localparam int unsigned SHAPE_LSB = 8;
  localparam int unsigned MBT_LSB = 0;
  localparam int unsigned CHROMA_LSB = 24;
  localparam int unsigned REFC_LSB = 16;
  // ----------------------------------------
  // Encodings and widths
  // ----------------------------------------
  localparam logic [2:0] SC_DUAL = 3'h7;
  localparam logic [5:0] WT_A = 6'h10;
  localparam logic [5:0] WT_B = 6'h15;
  localparam logic [5:0] WT_C = 6'h20;
  localparam logic [5:0] WT_D = 6'h2B;
  localparam logic [5:0] WT_E = 6'h30;
  localparam logic [6:0] WT_FULL = 7'h40;
  localparam logic [1:0] MB_16X16 = 2'h0;
  localparam logic [1:0] MB_16X8 = 2'h1;
  localparam logic [1:0] MB_8X16 = 2'h2;
  localparam logic [1:0] MB_8X8 = 2'h3;
  localparam logic [1:0] DIR_ILLEGAL = 2'h3;
  localparam logic [1:0] CHR_DC = 2'h0;
  localparam logic [1:0] CHR_PLANE = 2'h3;
  localparam int unsigned THR_W = 14;
  localparam int unsigned MVC_W = 10;
  localparam int unsigned PEN_W = 12;
  localparam logic [11:0] COST_MAX_EXT = 12'hFFF;
  localparam logic [11:0] COST_MAX_LEG = 12'h3FF;
  localparam logic [6:0] MV_CLAMP = 7'h40;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SKIP = 3'h1,
    ST_INTEGER = 3'h3,
    ST_REFINE = 3'h2,
    ST_INTRA = 3'h6,
    ST_DONE = 3'h7
  } msc_state_type;
endpackage

// ### testbench/msc_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module msc_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [2:0] search_control_select,
  input wire logic single_direction_force,
  input wire logic [1:0] chroma_mode,
  input wire logic [11:0] chroma_penalty_q,
  input wire logic lookup_req,
  input wire logic centre_valid,
  input wire logic start,
  input wire logic phase_skip,
  input wire logic phase_integer,
  input wire logic phase_refine,
  input wire logic phase_intra,
  input wire logic phase_done,
  input wire logic early_stop_q,
  input wire logic bidir_valid_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Bus answer lives one cycle only
  property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("rdata not zero outside read answer");
  property p_sdf; single_direction_force |-> search_control_select == msc_pkg::SC_DUAL;
  endproperty
  a_sdf: assert property (p_sdf)
    else $error("single direction forced without dual select");
  property p_chr_dc; ce && chroma_mode == msc_pkg::CHR_DC |=> chroma_penalty_q == 12'h000;
  endproperty
  a_chr_dc: assert property (p_chr_dc)
    else $error("dc chroma penalty not zero");
  property p_look; lookup_req && ce && !rd |=> centre_valid; endproperty
  a_look: assert property (p_look)
    else $error("lookup gave no answer");
  property p_look_n; !lookup_req |=> !centre_valid; endproperty
  a_look_n: assert property (p_look_n)
    else $error("centre valid without lookup");
  // Idle is the state with no phase flag up
  property p_start;
    start && ce && !(phase_skip || phase_integer || phase_refine || phase_intra || phase_done)
      |=> phase_skip || phase_integer;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not enter skip or integer phase");
  property p_early; $rose(early_stop_q) |-> phase_refine || phase_done; endproperty
  a_early: assert property (p_early)
    else $error("early stop left integer phase wrongly");
  property p_done; phase_done |=> !phase_done; endproperty
  a_done: assert property (p_done)
    else $error("done phase longer than one cycle");
  property p_bidir; bidir_valid_q |-> $past(search_control_select) == msc_pkg::SC_DUAL;
  endproperty
  a_bidir: assert property (p_bidir)
    else $error("bidir term valid without dual select");
endmodule

// ### testbench/msc_sender.sv
`timescale 1ns/100ps
// ----------------------------------------
// Message sender stand-in
// ----------------------------------------
module msc_sender (
  input wire logic ref_clk,
  input wire logic dual_req,
  output logic [2:0] search_control_select
);
  // Select changes only between messages, so it is registered
  always_ff @(posedge ref_clk) begin
    search_control_select <= dual_req ? msc_pkg::SC_DUAL : 3'h0;
  end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_top;
  logic ref_clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0, start = 0, step_done = 0, dual_req = 0;
  logic early_full_pel = 0, cost_mode_linear = 0, inter_all_8x8 = 0, large_transform_flag_in = 0;
  logic lookup_req = 0, lookup_bwd = 0;
  logic [7:0] addr = 8'h00, block_shape_input;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] search_control_select;
  logic [1:0] ref_index = 0, coeff_row = 0, coeff_col = 0, chroma_mode = 0, lookup_part = 0;
  logic [1:0] macroblock_type_input;
  logic [15:0] dist_16x16 = 16'hFFFF, dist_16x8 = 16'hFFFF, dist_8x8 = 16'hFFFF;
  logic [15:0] fwd_term = 16'h0100, bwd_term = 16'h0300;
  logic [5:0] result_vector_count = 0;
  logic [6:0] mv_distance = 0;
  logic phase_skip, phase_integer, phase_refine, phase_intra, phase_done, search_y_enable;
  logic single_direction_force, whole_block_bidir_decision, adaptive_walk_enable, early_stop_q;
  logic partition_ok_q, large_transform_flag_q, bidir_valid_q, centre_valid;
  logic [3:0] block_backward;
  logic [15:0] bidir_term_q, skip_threshold_q, ref_cost_q, centre_dx, centre_dy;
  logic [11:0] mv_cost_q, chroma_penalty_q;
  logic [5:0] wts [5] = '{msc_pkg::WT_A, msc_pkg::WT_B, msc_pkg::WT_C, msc_pkg::WT_D,
    msc_pkg::WT_E};
  int mismatches = 0, total_checks = 0;

  msc_control msc_control_inst (.*);
  msc_sender msc_sender_inst (.*);

  always #50 ref_clk = ~ref_clk;

  // Shared compare, bus cycles and lookup
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bw(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge ref_clk);
    wr <= 0;
  endtask
  task automatic br(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk);
    addr <= a; rd <= 1;
    @(posedge ref_clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  task automatic lk(logic [1:0] p, logic b, logic [15:0] dx, logic [15:0] dy);
    @(posedge ref_clk);
    lookup_req <= 1; lookup_part <= p; lookup_bwd <= b;
    @(posedge ref_clk);
    lookup_req <= 0;
    #1 chk(centre_valid, 1);
    chk(centre_dx, dx);
    chk(centre_dy, dy);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, far beyond the fewer than one hundred cycles used
  initial begin
    #1000000;
    mismatches++;
    complete_run;
  end

  initial begin
    logic [31:0] e;
    repeat (5) @(posedge ref_clk);
    nrst <= 1;
    br(msc_pkg::A_CTRL1, 32'h0);
    chk(search_y_enable, 1);
    bw(msc_pkg::A_CTRL1, 32'hEFFF_FFFF);
    br(msc_pkg::A_CTRL1, msc_pkg::CTRL1_MASK & 32'hEFFF_FFFF);
    chk(single_direction_force, 0);
    bw(msc_pkg::A_CTRL0, 32'hFFFF_FFFF);
    br(msc_pkg::A_CTRL0, msc_pkg::CTRL0_MASK);
    chk(search_y_enable, 0);
    chk(whole_block_bidir_decision, 1);
    br(8'h4C, 32'h0);
    br(8'h01, 32'h0);
    $display("test registers done");
    bw(msc_pkg::A_CTRL0, 32'h0);
    bw(8'h1C, 32'hFF5A_E4FF);
    br(8'h1C, 32'h005A_E403);
    chk(block_backward, 4'hC);
    chk(block_shape_input, 8'hE4);
    chk(macroblock_type_input, msc_pkg::MB_8X8);
    $display("test refine inputs done");
    dual_req <= 1;
    for (int i = 0; i < 5; i++) begin
      bw(msc_pkg::A_CTRL1, {10'h0, wts[i], 16'h0} | 32'h1000_0000);
      repeat (2) @(posedge ref_clk);
      e = (32'h100 * (64 - wts[i]) + 32'h300 * wts[i]) >> 6;
      #1 chk(bidir_term_q, e);
      chk(bidir_valid_q, 1);
      chk(single_direction_force, 1);
    end
    $display("test weights done");
    bw(8'h10, 32'h0302_0000);
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk);
      chroma_mode <= m[1:0];
      repeat (2) @(posedge ref_clk);
      #1 chk(chroma_penalty_q, m == 0 ? 0 : (m == 3 ? 6 : 3));
    end
    chk(ref_cost_q, 16'h0002);
    bw(8'h14, 32'h0602_0100);
    mv_distance <= 7'h03;
    @(posedge ref_clk);
    #1 chk(mv_cost_q, 12'h004);
    $display("test chroma done");
    bw(msc_pkg::A_CTRL0, 32'h0500_0020);
    dist_8x8 <= 16'h0002;
    early_full_pel <= 1;
    @(posedge ref_clk);
    start <= 1;
    @(posedge ref_clk);
    start <= 0;
    for (int n = 0; n < 20 && !phase_done; n++) @(posedge ref_clk) #1;
    chk(phase_done, 1);
    chk(early_stop_q, 1);
    chk(adaptive_walk_enable, 0);
    chk(partition_ok_q, 1);
    $display("test early exit done");
    bw(8'h28, 32'h0005_0003);
    bw(8'h44, 32'h0009_0007);
    lk(2'h0, 0, 16'h0003, 16'h0005);
    lk(2'h3, 1, 16'h0007, 16'h0009);
    $display("test centres done");
    complete_run;
  end
endmodule

bind msc_control msc_checker msc_checker_inst (.*);
